//--- verilog/link_delay_pkg.sv
// Summary of operation
// - each link derives its local multiframe clock by delaying the aligned one.
// - all lanes of a link are read in the same local multiframe period.
// - samples are released that many cycles after the local multiframe boundary.
// - the receive buffer delay accepts 0 to 12 processing cycles.
// - both delays count processing cycles, each 4/f frame clocks.
// - one processing cycle spans four lane byte periods.
// - a multiframe is 16 cycles at two octets per frame, 8 at one.
// - latency readback counts cycles from undelayed local boundary to first sample.
// - the latency readback wraps modulo the cycles per multiframe.
// - the internal multiframe clock aligns to the accepted reference edge.
// - a multiframe always holds 32 frames.
package link_delay_pkg;
	localparam logic [11:0] LATENCY_ADDR = 12'h302;
	localparam logic [11:0] MF_DELAY_ADDR = 12'h304;
	localparam logic [11:0] RELEASE_ADDR = 12'h306;
	localparam logic [7:0] MF_DELAY_RESET = 8'h00;
	localparam logic [7:0] RELEASE_RESET = 8'h00;
	localparam logic [7:0] MAX_RELEASE = 8'h0c;
	localparam int FRAMES_PER_MF = 32;
	localparam int BYTES_PER_CYCLE = 4;
	localparam logic [4:0] CYCLES_MF_F1 = 5'(FRAMES_PER_MF / BYTES_PER_CYCLE);
	localparam logic [4:0] CYCLES_MF_F2 = 5'(2 * FRAMES_PER_MF / BYTES_PER_CYCLE);
	localparam int LANES = 4;
	localparam int SAMPLE_W = 32;
	localparam int FIFO_DEPTH = 16;
	typedef struct packed {
		logic [11:0] addr;
		logic write;
		logic read;
		logic [7:0] wdata;
	} reg_req_type;
	typedef struct packed {
		logic valid;
		logic [LANES*SAMPLE_W-1:0] data;
	} sample_type;
endpackage

//--- verilog/link_delay_buffer_release.sv
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
	logic push, pop;
	// pointer arithmetic
	always_comb begin
		push = inValid && inReady;
		pop = outValid && outReady;
		next_wrPtr = wrPtr + (AW+1)'(push);
		next_rdPtr = rdPtr + (AW+1)'(pop);
	end
	assign inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
	assign outValid = wrPtr != rdPtr;
	assign outData = mem[rdPtr[AW-1:0]];
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
		end
	end
	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr[AW-1:0]] <= inData;
		end
	end
endmodule // sample_fifo

module link_delay_buffer_release #(
	parameter int LANES = link_delay_pkg::LANES,
	parameter int SAMPLE_W = link_delay_pkg::SAMPLE_W,
	parameter int FIFO_DEPTH = link_delay_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire link_delay_pkg::reg_req_type regReq,
	output logic [7:0] regRdata,
	output logic regRvalid,
	// mode and alignment
	input wire logic twoOctets,
	input wire logic alignedBoundary,
	input wire logic firstSample,
	// lane samples from deframer
	input wire link_delay_pkg::sample_type laneIn,
	output logic laneReady,
	// released samples
	output link_delay_pkg::sample_type sampleOut,
	input wire logic sampleReady,
	// local multiframe clock
	output logic localBoundary
);
	import link_delay_pkg::*;
	logic rstMeta, rstn;
	logic [7:0] mfDelay, next_mfDelay, relDelay, next_relDelay;
	logic [7:0] latency, next_latency, next_rdata;
	logic next_rvalid;
	logic [4:0] alignCnt, next_alignCnt, localCnt, next_localCnt, cyclesMf;
	logic [3:0] relCnt, next_relCnt;
	logic releasing, next_releasing, held, next_held;
	logic fifoValid, fifoReady;
	logic [LANES*SAMPLE_W-1:0] fifoData;
	logic next_outValid;
	logic [LANES*SAMPLE_W-1:0] next_outData;

	function automatic logic [4:0] wrapInc(input logic [4:0] v, input logic [4:0] m);
		wrapInc = (v + 5'h01 >= m) ? 5'h00 : v + 5'h01;
	endfunction

	// reset release synchroniser
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta <= 1'b0;
			rstn <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstn <= rstMeta;
		end
	end

	assign cyclesMf = twoOctets ? CYCLES_MF_F2 : CYCLES_MF_F1;

	// register access
	always_comb begin
		next_mfDelay = mfDelay;
		next_relDelay = relDelay;
		next_rdata = regRdata;
		next_rvalid = regReq.read;
		if (regReq.write && regReq.addr == MF_DELAY_ADDR) begin
			next_mfDelay = regReq.wdata;
		end
		if (regReq.write && regReq.addr == RELEASE_ADDR) begin
			next_relDelay = regReq.wdata;
		end
		if (regReq.read) begin
			unique case (regReq.addr)
				LATENCY_ADDR: next_rdata = latency;
				MF_DELAY_ADDR: next_rdata = mfDelay;
				RELEASE_ADDR: next_rdata = relDelay;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// multiframe counters and latency capture
	always_comb begin
		next_alignCnt = wrapInc(alignCnt, cyclesMf);
		if (alignedBoundary) begin
			next_alignCnt = 5'h01;
		end
		next_localCnt = (alignedBoundary && mfDelay == 8'h00) ? 5'h01 :
			(alignCnt == mfDelay[4:0] ? 5'h01 : wrapInc(localCnt, cyclesMf));
		next_latency = latency;
		if (firstSample) begin
			next_latency = {3'h0, alignCnt};
		end
	end
	assign localBoundary = localCnt == 5'h00;

	// release timing
	always_comb begin
		next_releasing = releasing;
		next_held = held;
		next_relCnt = relCnt;
		if (held && localBoundary) begin
			next_relCnt = (relDelay > MAX_RELEASE) ? MAX_RELEASE[3:0] : relDelay[3:0];
			next_held = 1'b0;
			if (relDelay == 8'h00) begin
				next_releasing = 1'b1;
			end
		end else if (!held && !releasing && relCnt != 4'h0) begin
			next_relCnt = relCnt - 4'h1;
			if (relCnt == 4'h1) begin
				next_releasing = 1'b1;
			end
		end
		// new first sample wins over a boundary in the same cycle
		if (firstSample) begin
			next_held = 1'b1;
			next_releasing = 1'b0;
		end
	end

	sample_fifo #(.WIDTH(LANES*SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rstn(rstn),
		.inValid(laneIn.valid),
		.inReady(laneReady),
		.inData(laneIn.data),
		.outValid(fifoValid),
		.outReady(fifoReady),
		.outData(fifoData)
	);

	// output stage
	assign fifoReady = releasing && (!sampleOut.valid || sampleReady);
	always_comb begin
		next_outValid = sampleOut.valid && !sampleReady;
		next_outData = sampleOut.data;
		if (fifoReady && fifoValid) begin
			next_outValid = 1'b1;
			next_outData = fifoData;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mfDelay <= MF_DELAY_RESET;
			relDelay <= RELEASE_RESET;
			latency <= 8'h00;
			regRdata <= 8'h00;
			regRvalid <= 1'b0;
			alignCnt <= 5'h00;
			localCnt <= 5'h00;
			relCnt <= 4'h0;
			releasing <= 1'b0;
			held <= 1'b0;
			sampleOut <= '0;
		end else begin
			mfDelay <= next_mfDelay;
			relDelay <= next_relDelay;
			latency <= next_latency;
			regRdata <= next_rdata;
			regRvalid <= next_rvalid;
			alignCnt <= next_alignCnt;
			localCnt <= next_localCnt;
			relCnt <= next_relCnt;
			releasing <= next_releasing;
			held <= next_held;
			sampleOut.valid <= next_outValid;
			sampleOut.data <= next_outData;
		end
	end

	// checks
	// wrap check
	chk_latency_wrap: assert property (@(posedge clk) disable iff (!rstn)
		firstSample |=> latency < {3'h0, cyclesMf}) else $error("latency out of range");
	chk_latency_capture: assert property (@(posedge clk) disable iff (!rstn)
		firstSample |=> latency == {3'h0, $past(alignCnt)}) else $error("latency not captured");
	chk_local_delay: assert property (@(posedge clk) disable iff (!rstn)
		(alignCnt == mfDelay[4:0] && !alignedBoundary && mfDelay != 8'h00) |=> localCnt == 5'h01)
		else $error("local clock not delayed");
	chk_mf_length: assert property (@(posedge clk) disable iff (!rstn)
		alignCnt < cyclesMf || $past(alignedBoundary)) else $error("multiframe overrun");
	chk_no_early: assert property (@(posedge clk) disable iff (!rstn)
		held |-> !releasing) else $error("release before boundary");
	chk_delay_bound: assert property (@(posedge clk) disable iff (!rstn)
		relCnt <= MAX_RELEASE[3:0]) else $error("release delay above limit");
	chk_release_time: assert property (@(posedge clk) disable iff (!rstn)
		(held && localBoundary && relDelay == 8'h00) |=> releasing) else $error("zero delay stalled");
	chk_output_hold: assert property (@(posedge clk) disable iff (!rstn)
		(sampleOut.valid && !sampleReady) |=> sampleOut.valid && $stable(sampleOut.data))
		else $error("output dropped under stall");
	cov_release: cover property (@(posedge clk) disable iff (!rstn) $rose(releasing));
	cov_full: cover property (@(posedge clk) disable iff (!rstn) !laneReady);
	cov_wrap: cover property (@(posedge clk) disable iff (!rstn) firstSample && alignCnt == 5'h00);
endmodule // link_delay_buffer_release

//--- bench/lane_tx_model.sv
`timescale 1ns/1ps
module lane_tx_model (
	// clock and mode
	input wire logic clk,
	input wire logic twoOctets,
	// lane stream
	output link_delay_pkg::sample_type laneIn,
	input wire logic laneReady,
	// alignment events
	output logic alignedBoundary,
	output logic firstSample
);
	import link_delay_pkg::*;
	int cnt = 0;
	int taken = 0;
	initial begin
		laneIn = '0;
		firstSample = 0;
		alignedBoundary = 0;
	end
	always @(negedge clk) begin
		alignedBoundary <= (cnt == 0);
		cnt <= (cnt + 1) % (twoOctets ? 16 : 8);
	end
	// word held until taken
	task automatic send(input logic [LANES*SAMPLE_W-1:0] d);
		laneIn.valid = 1;
		laneIn.data = d;
		while (!laneReady) @(negedge clk);
		@(negedge clk);
		taken++;
	endtask
	// released lines show the inverse
	task automatic idle();
		laneIn.valid = 0;
		laneIn.data = ~laneIn.data;
	endtask
	task automatic mark();
		firstSample = 1;
		@(negedge clk);
		firstSample = 0;
	endtask
endmodule // lane_tx_model

//--- bench/link_delay_buffer_release_test.sv
`timescale 1ns/1ps
module link_delay_buffer_release_test;
	import link_delay_pkg::*;
	logic clk = 0, resetn = 0, twoOctets = 0, sampleReady = 0;
	logic regRvalid, laneReady, localBoundary, alignedBoundary, firstSample;
	logic [7:0] regRdata;
	reg_req_type regReq = '0;
	sample_type laneIn, sampleOut;
	int bad_count = 0, compares = 0, seed = 32'h9d06, cyc = 0;
	int ac = 0, cpm = 8, lat = 0, bT, vT, mfd = 0, rel, armed = 0, lbOn = 0, mn, mx;
	logic [LANES*SAMPLE_W-1:0] expQ[$];
	always #2 clk = ~clk;
	link_delay_buffer_release dut_u (.clk(clk), .resetn(resetn), .regReq(regReq),
		.regRdata(regRdata), .regRvalid(regRvalid), .twoOctets(twoOctets),
		.alignedBoundary(alignedBoundary), .firstSample(firstSample),
		.laneIn(laneIn), .laneReady(laneReady), .sampleOut(sampleOut),
		.sampleReady(sampleReady), .localBoundary(localBoundary));
	lane_tx_model tx_u (.clk(clk), .twoOctets(twoOctets), .laneIn(laneIn),
		.laneReady(laneReady), .alignedBoundary(alignedBoundary),
		.firstSample(firstSample));
	task automatic cmp8(string n, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmpw(string n, logic [LANES*SAMPLE_W-1:0] e, g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one register access, then idle
	task automatic acc(logic [11:0] a, logic w, logic [7:0] d);
		regReq = '{addr: a, write: w, read: !w, wdata: d};
		@(negedge clk);
		regReq = '0;
		@(negedge clk);
	endtask
	// read answer is checked in the cycle it stands
	task automatic rd(logic [11:0] a, logic [7:0] e);
		regReq = '{addr: a, write: 1'b0, read: 1'b1, wdata: 8'h00};
		@(negedge clk);
		regReq = '0;
		cmp8("regRvalid", 8'h01, 8'(regRvalid));
		cmp8("regRdata", e, regRdata);
		@(negedge clk);
	endtask
	task automatic burst(int n);
		logic [LANES*SAMPLE_W-1:0] d;
		for (int i = 0; i < n; i++) begin
			d = {4{$random(seed)}};
			expQ.push_back(d);
			tx_u.send(d);
		end
		tx_u.idle();
	endtask
	// random stalls on the drain side
	always @(negedge clk) sampleReady <= $random(seed);
	// mirror of alignment count, local boundary and release order
	always @(posedge clk) begin
		cyc++;
		if (cyc > 6000) begin
			bad_count++;
			close_out();
		end
		// ac follows the aligned count, which restarts at one after the boundary
		if (lbOn) cmp8("localBoundary", 8'(ac == mfd), 8'(localBoundary));
		if (firstSample) lat = ac;
		ac = alignedBoundary ? 1 : (ac + 1) % cpm;
		if (armed && localBoundary && bT < 0) bT = cyc;
		if (sampleOut.valid === 1'b1) begin
			if (vT < 0) vT = cyc;
			if (sampleReady) cmpw("sample", expQ.pop_front(), sampleOut.data);
		end
	end
	initial begin
		for (int m = 0; m < 2; m++) begin
			@(negedge clk);
			resetn = 0;
			twoOctets = m[0];
			cpm = m ? 16 : 8;
			lbOn = 0;
			armed = 0;
			bT = -1;
			vT = -1;
			tx_u.taken = 0;
			repeat (2) @(negedge clk);
			resetn = 1;
			repeat (3) @(negedge clk);
			rd(MF_DELAY_ADDR, 8'h00);
			rd(RELEASE_ADDR, 8'h00);
			acc(LATENCY_ADDR, 1, 8'ha5);
			rd(LATENCY_ADDR, 8'h00);
			rd(12'h300, 8'h00);
			// known min and max delays set both values in the one-octet pass
			mn = 1 + {$random(seed)} % 40;
			mx = mn + {$random(seed)} % 7;
			// legal settings, zero multiframe delay and release delay 12 in the two-octet pass
			mfd = m ? 0 : (mn - 1) % cpm;
			rel = m ? 12 : (mx + 1) - (mn - 1);
			acc(MF_DELAY_ADDR, 1, 8'(mfd));
			acc(RELEASE_ADDR, 1, 8'(rel));
			rd(MF_DELAY_ADDR, 8'(mfd));
			rd(RELEASE_ADDR, 8'(rel));
			repeat (40) @(negedge clk);
			lbOn = 1;
			fork
				burst(20);
			join_none
			for (int i = 0; i < 100 && laneReady; i++) @(negedge clk);
			repeat (2) @(negedge clk);
			cmp8("filled", 8'd16, 8'(tx_u.taken));
			while (!localBoundary) @(negedge clk);
			@(negedge clk);
			armed = 1;
			tx_u.mark();
			for (int i = 0; i < 300 && expQ.size() > 0; i++) @(negedge clk);
			cmp8("drained", 8'h00, 8'(expQ.size()));
			cmp8("release", 8'(rel + 2), 8'(vT - bT));
			rd(LATENCY_ADDR, 8'(lat));
		end
		close_out();
	end
endmodule // link_delay_buffer_release_test
